//--- logic/dmt_tuning_regs.sv
// register bank tuning the delta-sigma dac modulators
// Overview of operation
// - two-bit shuffle field: none, internal, global
// - shuffle field resets to global
// - bit 0 picks dither polarity, resets zero
// - left path scale select, resets zero
// - right path scale select, resets zero
// - left primary coefficient zero bits
// - right primary coefficient zero bits, reset normal
// - left primary loop gain select
// - left primary upper bit count
// - right primary loop gain select
// - right primary upper bit count
// - secondary coefficient zero bits, reset normal
`timescale 1ns/1ps
`include "dmt_defs.svh"
module dmt_tuning_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // host control port, one access per strobe
  input wire dmt_pkg::dmt_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // modulator controls
  output dmt_pkg::dmt_cfg_s cfg
);
  import dmt_pkg::*;
  dmt_state_s st_reg;
  dmt_state_s st_next;
  logic rvalid_reg;
  logic sh_int;
  logic sh_glb;

  // masks keep reserved bits at zero so they never reach the modulators
  always_comb begin
    st_next = st_reg;
    if (req.wr) begin
      unique case (req.addr)
        `DMT_OFS_SHUF: st_next.shuf = req.wdata & `DMT_MASK_SHUF;
        `DMT_OFS_SCALE: st_next.scale = req.wdata & `DMT_MASK_SCALE;
        `DMT_OFS_PCOEF: st_next.pcoef = req.wdata;
        `DMT_OFS_PGAIN: st_next.pgain = req.wdata & `DMT_MASK_PGAIN;
        `DMT_OFS_SCOEF: st_next.scoef = req.wdata;
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        `DMT_OFS_SHUF: st_next.rdata = st_reg.shuf;
        `DMT_OFS_SCALE: st_next.rdata = st_reg.scale;
        `DMT_OFS_PCOEF: st_next.rdata = st_reg.pcoef;
        `DMT_OFS_PGAIN: st_next.rdata = st_reg.pgain;
        `DMT_OFS_SCOEF: st_next.rdata = st_reg.scoef;
        default: st_next.rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.shuf <= 8'h20;
      rvalid_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      rvalid_reg <= req.rd;
    end
  end

  dmt_shuffle_dec u_dec (
    .output_shuffle_mode(dmt_shuffle_e'(st_reg.shuf[`DMT_SHUF_LSB +: 2])),
    .shuffle_int(sh_int),
    .shuffle_global(sh_glb)
  );

  assign rdata = st_reg.rdata;
  assign rvalid = rvalid_reg;

  always_comb begin
    cfg.shuffle_int = sh_int;
    cfg.shuffle_global = sh_glb;
    cfg.dither_polarity = st_reg.shuf[`DMT_DITHER_POLARITY_BIT];
    cfg.left_path_scale = st_reg.scale[`DMT_LSC_BIT];
    cfg.right_path_scale = st_reg.scale[`DMT_RSC_BIT];
    cfg.left_pri = st_reg.pcoef[7:4];
    cfg.right_pri = st_reg.pcoef[3:0];
    cfg.left_sec = st_reg.scoef[7:4];
    cfg.right_sec = st_reg.scoef[3:0];
    cfg.left_pri_loop_gain = st_reg.pgain[`DMT_LG_BIT];
    cfg.left_pri_upper_count = st_reg.pgain[`DMT_LUB_BIT];
    cfg.right_pri_loop_gain = st_reg.pgain[`DMT_RG_BIT];
    cfg.right_pri_upper_count = st_reg.pgain[`DMT_RUB_BIT];
  end

  // assertions
  a_shuf_reset: assert property (@(posedge clk_sys) $rose(nrst) |->
    cfg.shuffle_global && !cfg.shuffle_int)
    else $error("shuffle not global after reset");
  a_shuf_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_SHUF |=>
    cfg.shuffle_int == ($past(req.wdata[5:4]) == 2'h1) &&
    cfg.shuffle_global == ($past(req.wdata[5:4]) == 2'h2))
    else $error("shuffle mode decode wrong");
  a_dither_polarity_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_SHUF |=>
    cfg.dither_polarity == $past(req.wdata[0]))
    else $error("dither polarity not taken");
  a_scale_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_SCALE |=>
    cfg.left_path_scale == $past(req.wdata[7]) &&
    cfg.right_path_scale == $past(req.wdata[3]))
    else $error("path scale not taken");
  a_pcoef_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_PCOEF |=>
    {cfg.left_pri, cfg.right_pri} == $past(req.wdata))
    else $error("primary coefficient bits wrong");
  a_scoef_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_SCOEF |=>
    {cfg.left_sec, cfg.right_sec} == $past(req.wdata))
    else $error("secondary coefficient bits wrong");
  a_gain_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_PGAIN |=>
    cfg.left_pri_loop_gain == $past(req.wdata[7]) &&
    cfg.left_pri_upper_count == $past(req.wdata[5]) &&
    cfg.right_pri_loop_gain == $past(req.wdata[3]) &&
    cfg.right_pri_upper_count == $past(req.wdata[1]))
    else $error("gain or upper count not taken");
  a_rsvd_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.rd && req.addr == `DMT_OFS_PGAIN |=>
    (rdata & 8'h55) == 8'h00)
    else $error("reserved bits read nonzero");
  a_pcoef_reset: assert property (@(posedge clk_sys) $rose(nrst) |->
    {cfg.left_pri, cfg.right_pri, cfg.left_sec} == '0)
    else $error("coefficient bits not normal after reset");
  a_read_back: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `DMT_OFS_SCALE ##1
    req.rd && !req.wr && req.addr == `DMT_OFS_SCALE |=>
    rdata == ($past(req.wdata, 2) & 8'h88) && rvalid)
    else $error("scale read back wrong");
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.rd && (req.addr < `DMT_OFS_SHUF || req.addr > `DMT_OFS_SCOEF) |=>
    rdata == 8'h00 && rvalid)
    else $error("unmapped read not zero");
  // a read in the same cycle as a write must return the value before it
  a_same_cycle_rd: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wr && req.rd && req.addr == `DMT_OFS_PCOEF |=>
    rdata == $past(st_reg.pcoef) && rvalid)
    else $error("same cycle read not old value");
  a_rvalid_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !req.rd |=> !rvalid)
    else $error("read valid without a read");
endmodule

//--- logic/dmt_defs.svh
// offsets, field positions and reset values of the modulator tuning bank
`ifndef DMT_DEFS_SVH
`define DMT_DEFS_SVH
`define DMT_ADDR_W 8
`define DMT_OFS_SHUF 8'h10
`define DMT_OFS_SCALE 8'h11
`define DMT_OFS_PCOEF 8'h12
`define DMT_OFS_PGAIN 8'h13
`define DMT_OFS_SCOEF 8'h14
`define DMT_SHUF_LSB 4
`define DMT_DITHER_POLARITY_BIT 0
`define DMT_LSC_BIT 7
`define DMT_RSC_BIT 3
`define DMT_LG_BIT 7
`define DMT_LUB_BIT 5
`define DMT_RG_BIT 3
`define DMT_RUB_BIT 1
`define DMT_SHUF_RST 2'h2
`define DMT_MASK_SHUF 8'h31
`define DMT_MASK_SCALE 8'h88
`define DMT_MASK_PGAIN 8'haa
`endif

//--- logic/dmt_pkg.sv
// types shared by the modulator tuning bank
package dmt_pkg;
  typedef enum logic [1:0] {
    DMT_SHUF_NONE = 2'b00,
    DMT_SHUF_INT = 2'b01,
    DMT_SHUF_GLOBAL = 2'b10,
    DMT_SHUF_NONE_ALT = 2'b11
  } dmt_shuffle_e;
  typedef struct packed {
    logic a_zero;
    logic b_first_zero;
    logic b_second_zero;
    logic b_third_zero;
  } dmt_coef_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmt_req_s;
  typedef struct packed {
    logic shuffle_int;
    logic shuffle_global;
    logic dither_polarity;
    logic left_path_scale;
    logic right_path_scale;
    dmt_coef_s left_pri;
    dmt_coef_s right_pri;
    dmt_coef_s left_sec;
    dmt_coef_s right_sec;
    logic left_pri_loop_gain;
    logic left_pri_upper_count;
    logic right_pri_loop_gain;
    logic right_pri_upper_count;
  } dmt_cfg_s;
  typedef struct packed {
    logic [7:0] shuf;
    logic [7:0] scale;
    logic [7:0] pcoef;
    logic [7:0] pgain;
    logic [7:0] scoef;
    logic [7:0] rdata;
  } dmt_state_s;
endpackage

//--- logic/dmt_shuffle_dec.sv
// decodes the output shuffle mode into its steering enables
`timescale 1ns/1ps
module dmt_shuffle_dec (
  // mode in
  input wire dmt_pkg::dmt_shuffle_e output_shuffle_mode,
  // steering out
  output logic shuffle_int,
  output logic shuffle_global
);
  import dmt_pkg::*;
  always_comb begin
    shuffle_int = 1'b0;
    shuffle_global = 1'b0;
    unique case (output_shuffle_mode)
      DMT_SHUF_INT: shuffle_int = 1'b1;
      DMT_SHUF_GLOBAL: shuffle_global = 1'b1;
      DMT_SHUF_NONE, DMT_SHUF_NONE_ALT: ;
    endcase
  end
endmodule

//--- verification/dmt_tuning_regs_bench.sv
// self-checking bench for the modulator tuning register bank
`timescale 1ns/1ps
`include "dmt_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin \
  n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); \
  end end
module dmt_tuning_regs_bench;
  import dmt_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  dmt_req_s req = '0;
  logic [7:0] rdata;
  logic rvalid;
  dmt_cfg_s cfg;
  logic [7:0] e [5];
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  dmt_tuning_regs u_dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .cfg(cfg)
  );
  // expected controls rebuilt from the shadow copy, never from dut outputs
  function automatic dmt_cfg_s mk();
    return {e[0][5:4] == 2'h1, e[0][5:4] == 2'h2, e[0][0], e[1][7],
      e[1][3], e[2], e[4], e[3][7], e[3][5], e[3][3], e[3][1]};
  endfunction
  // reserved positions are dropped on write, so the shadow masks them too
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      `DMT_OFS_SHUF: return `DMT_MASK_SHUF;
      `DMT_OFS_SCALE: return `DMT_MASK_SCALE;
      `DMT_OFS_PGAIN: return `DMT_MASK_PGAIN;
      default: return 8'hff;
    endcase
  endfunction
  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reset_dut();
    nrst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #10;
    nrst = 1'b1;
    e = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
    `CHK(cfg, mk())
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #10 req = {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    #10 req = '0;
    if (a >= 8'h10 && a <= 8'h14)
      e[a - 8'h10] = d & msk(a);
    `CHK(cfg, mk())
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] x;
    x = (a >= 8'h10 && a <= 8'h14) ? e[a - 8'h10] : 8'h00;
    @(posedge clk_sys);
    #10 req = {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    #10 req = '0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, x)
    @(posedge clk_sys);
    #10;
    `CHK(rvalid, 1'b0)
  endtask
  task automatic wrd(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    rd(a);
  endtask
  // write then read on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #10 req = {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    #10 req = {1'b0, 1'b1, a, 8'h00};
    e[a - 8'h10] = d & msk(a);
    @(posedge clk_sys);
    #10 req = '0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e[a - 8'h10])
    `CHK(cfg, mk())
  endtask
  // write and read in one cycle, the read returns the old value
  task automatic wr_and_rd(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    x = e[a - 8'h10];
    @(posedge clk_sys);
    #10 req = {1'b1, 1'b1, a, d};
    @(posedge clk_sys);
    #10 req = '0;
    e[a - 8'h10] = d & msk(a);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, x)
    `CHK(cfg, mk())
  endtask
  task automatic rd_all();
    for (int i = 0; i < 5; i++)
      rd(8'(8'h10 + i));
  endtask
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    reset_dut();
    rd_all();
    for (int m = 0; m < 4; m++) begin
      wrd(8'h10, 8'hce | 8'(m << 4));
    end
    wrd(8'h10, 8'h01);
    wrd(8'h11, 8'hff);
    wrd(8'h11, 8'h80);
    wrd(8'h11, 8'h08);
    wrd(8'h12, 8'ha5);
    wrd(8'h12, 8'h5a);
    wrd(8'h13, 8'hff);
    wrd(8'h13, 8'h82);
    wrd(8'h13, 8'h28);
    wrd(8'h14, 8'h3c);
    wrd(8'h14, 8'hc3);
    wrd(8'h15, 8'hff);
    wrd(8'h0f, 8'hff);
    wr_rd(8'h11, 8'h8f);
    wr_and_rd(8'h12, 8'h33);
    rd(8'h12);
    // second reset in mid-run must restore every default
    reset_dut();
    rd_all();
    end_sim();
  end
endmodule
